// ### rtl/ech_consts.vh
// Constants shared by the echo canceller host port and its helpers.
// Assumes inclusion by bare name from files in the same rtl folder.
`ifndef ECH_CONSTS_VH
`define ECH_CONSTS_VH

// ------------------------------------------------------------------
// Host bus shape
// ------------------------------------------------------------------
`define ECH_ADDR_W 11
`define ECH_DATA_W 8
`define ECH_PIN_W 23
`define ECH_PIN_RST 23'h700000

// ------------------------------------------------------------------
// Locally held registers
// ------------------------------------------------------------------
`define ECH_ADDR_MAIN_CTRL 11'h000
`define ECH_ADDR_IRQ_FIFO 11'h001
`define ECH_ADDR_IRQ_STAT 11'h002
`define ECH_MAIN_CTRL_RST 8'h00
`define ECH_CTRL_ODE_BIT 6
`define ECH_FIFO_VALID_BIT 7
`define ECH_STAT_OVF_BIT 7

// ------------------------------------------------------------------
// Interrupt FIFO and start-up
// ------------------------------------------------------------------
`define ECH_CHAN_W 5
`define ECH_FIFO_DEPTH 32
`define ECH_FIFO_PTR_W 5
`define ECH_FIFO_CNT_W 6
`define ECH_INIT_CYCLES 5'd16
`define ECH_INIT_CNT_W 5

`endif

// ### rtl/ech_sync2.v
// Two-stage synchroniser, one flip-flop pair per bit.
// Assumes inputs come from pins outside the clk_sys_i domain.
`timescale 1ns/1ps

module ech_sync2 #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  input wire clk_sys_i,          // System clock
  input wire rst_i,              // Async reset, active high
  input wire [WIDTH-1:0] async_i, // Raw pin levels
  output wire [WIDTH-1:0] sync_o  // Synchronised levels
);

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
      reg meta_reg;
      reg sync_reg;
      // First stage feeds only the second stage
      always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
          meta_reg <= RST_VAL[gi];
          sync_reg <= RST_VAL[gi];
        end else begin
          meta_reg <= async_i[gi];
          sync_reg <= meta_reg;
        end
      end
      assign sync_o[gi] = sync_reg;
    end
  endgenerate

endmodule

// ### rtl/ech_irq_fifo.v
// Interrupt FIFO holding channel numbers of pending channel interrupts.
// Assumes push and pop come from logic on clk_sys_i.
`timescale 1ns/1ps
`include "ech_consts.vh"

module ech_irq_fifo (
  input wire clk_sys_i,                        // System clock
  input wire rst_i,                            // Async reset, active high
  input wire push_i,                           // Store one channel number
  input wire [`ECH_CHAN_W-1:0] push_data_i,    // Channel number to store
  input wire pop_i,                            // Drop the oldest entry
  output wire [`ECH_CHAN_W-1:0] pop_data_o,    // Oldest entry
  output wire empty_o,                         // No entry pending
  output wire full_o,                          // No room left
  output wire [`ECH_FIFO_CNT_W-1:0] count_o    // Entries pending
);

  reg [`ECH_FIFO_PTR_W-1:0] wr_ptr_reg;
  reg [`ECH_FIFO_PTR_W-1:0] rd_ptr_reg;
  reg [`ECH_FIFO_CNT_W-1:0] count_reg;
  reg [`ECH_CHAN_W-1:0] mem_reg [0:`ECH_FIFO_DEPTH-1];
  wire do_pop;
  wire do_push;

  assign empty_o = (count_reg == {`ECH_FIFO_CNT_W{1'b0}});
  assign full_o = (count_reg == `ECH_FIFO_DEPTH);
  assign count_o = count_reg;
  assign pop_data_o = mem_reg[rd_ptr_reg];
  assign do_pop = pop_i && !empty_o;
  // A push into a full FIFO is lost; the caller flags the overflow
  assign do_push = push_i && !full_o;

  genvar gi;
  generate
    for (gi = 0; gi < `ECH_FIFO_DEPTH; gi = gi + 1) begin : g_entry
      always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
          mem_reg[gi] <= {`ECH_CHAN_W{1'b0}};
        end else if (do_push && (wr_ptr_reg == gi)) begin
          mem_reg[gi] <= push_data_i;
        end
      end
    end
  endgenerate

  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr_reg <= {`ECH_FIFO_PTR_W{1'b0}};
      rd_ptr_reg <= {`ECH_FIFO_PTR_W{1'b0}};
      count_reg <= {`ECH_FIFO_CNT_W{1'b0}};
    end else begin
      if (do_push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (do_push && !do_pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (do_pop && !do_push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule

// ### rtl/ech_host_port.v
// Non-multiplexed 8-bit host port of the multi-channel echo canceller.
// Assumes open-drain pins are resolved outside, with pull-ups, and that
// the canceller core answers reads in the cycle its read strobe is high.
//
// Operation
// - The interrupt request output is pulled low whenever any channel raises an interrupt.
// - The interrupt request returns high only after every pending FIFO entry has been read.
// - An access happens only while both data strobe and chip select are low.
// - Chip select low activates the port, and strobes are ignored while it is high.
// - The read/write line sets the data bus direction, the device drives only on reads.
// - Data moves one byte per access on the shared 8-bit bidirectional bus.
// - Transfer acknowledge is pulled low to signal that the transfer has completed.
// - All eleven address lines are decoded to select a register.
// - PCM output drivers are enabled only when the drive-enable pin and control bit 6 are high.
// - If either the drive-enable pin or the control bit is low, both PCM outputs float.
// - After reset release the port initialises and reloads the main control register with its default.
`timescale 1ns/1ps
`include "ech_consts.vh"

module ech_host_port (
  input wire clk_sys_i,                              // 20 MHz system clock
  input wire rst_i,                                  // Async reset, active high
  input wire cs_n_i,                                 // Chip select pin, active low
  input wire data_strobe_n_i,                        // Data strobe pin, active low
  input wire rd_wr_n_i,                              // High read, low write
  input wire [`ECH_ADDR_W-1:0] host_addr_bus_i,      // Register address pins
  input wire [`ECH_DATA_W-1:0] host_data_bus_i,      // Data pins, input side
  output wire [`ECH_DATA_W-1:0] host_data_bus_o,     // Data pins, output side
  output wire host_data_bus_oe_o,                    // Data pins driven
  output wire transfer_ack_n_o,                      // Acknowledge level
  output wire transfer_ack_n_oe_o,                   // Acknowledge pulled low
  output wire irq_n_o,                               // Interrupt level
  output wire irq_n_oe_o,                            // Interrupt pulled low
  input wire output_drive_enable_i,                  // PCM drive enable pin
  output wire pcm_drive_en_o,                        // Enable of both PCM outputs
  input wire chan_irq_i,                             // Channel interrupt pulse
  input wire [`ECH_CHAN_W-1:0] chan_irq_id_i,        // Channel raising it
  output wire core_wr_o,                             // Core write strobe
  output wire core_rd_o,                             // Core read strobe
  output wire [`ECH_ADDR_W-1:0] core_addr_o,         // Core register address
  output wire [`ECH_DATA_W-1:0] core_wdata_o,        // Core write data
  input wire [`ECH_DATA_W-1:0] core_rdata_i,         // Core read data
  output wire [`ECH_DATA_W-1:0] main_ctrl_o,         // Main control register
  output wire init_done_o                            // Start-up finished
);

  // ------------------------------------------------------------------
  // States of the access sequencer
  // ------------------------------------------------------------------
  localparam [2:0] ST_INIT = 3'h0;
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_REQ = 3'h2;
  localparam [2:0] ST_DATA = 3'h3;
  localparam [2:0] ST_ACK = 3'h4;

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  wire [`ECH_PIN_W-1:0] pins_raw;
  wire [`ECH_PIN_W-1:0] pins_sync;
  wire ode_s;
  wire cs_n_s;
  wire ds_n_s;
  wire rd_s;
  wire [`ECH_ADDR_W-1:0] addr_s;
  wire [`ECH_DATA_W-1:0] data_s;
  wire sel_s;

  assign pins_raw = {output_drive_enable_i, cs_n_i, data_strobe_n_i, rd_wr_n_i,
                     host_addr_bus_i, host_data_bus_i};

  // Strobes idle high so reset never looks like an access
  ech_sync2 #(
    .WIDTH(`ECH_PIN_W),
    .RST_VAL(`ECH_PIN_RST)
  ) u_pin_sync (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .async_i(pins_raw),
    .sync_o(pins_sync)
  );

  assign ode_s = pins_sync[22];
  assign cs_n_s = pins_sync[21];
  assign ds_n_s = pins_sync[20];
  assign rd_s = pins_sync[19];
  assign addr_s = pins_sync[18:8];
  assign data_s = pins_sync[7:0];
  assign sel_s = !cs_n_s && !ds_n_s;

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  reg [2:0] state_reg;
  reg [`ECH_INIT_CNT_W-1:0] init_cnt_reg;
  reg init_done_reg;
  reg [`ECH_ADDR_W-1:0] addr_reg;
  reg [`ECH_DATA_W-1:0] wdata_reg;
  reg rd_reg;
  reg [`ECH_DATA_W-1:0] ctrl_reg;
  reg ovf_reg;
  reg [`ECH_DATA_W-1:0] dout_reg;
  reg dout_oe_reg;
  reg ack_oe_reg;
  reg irq_oe_reg;
  reg pcm_en_reg;
  reg core_wr_reg;
  reg core_rd_reg;

  // ------------------------------------------------------------------
  // Interrupt FIFO
  // ------------------------------------------------------------------
  wire [`ECH_CHAN_W-1:0] fifo_head;
  wire fifo_empty;
  wire fifo_full;
  wire [`ECH_FIFO_CNT_W-1:0] fifo_count;
  wire fifo_pop;
  wire hit_ctrl;
  wire hit_fifo;
  wire hit_stat;
  wire hit_local;
  wire stat_read;

  // Full eleven-bit compare, no aliasing of the local registers
  assign hit_ctrl = (addr_reg == `ECH_ADDR_MAIN_CTRL);
  assign hit_fifo = (addr_reg == `ECH_ADDR_IRQ_FIFO);
  assign hit_stat = (addr_reg == `ECH_ADDR_IRQ_STAT);
  assign hit_local = hit_ctrl || hit_fifo || hit_stat;
  // One entry leaves per read access, taken as the byte is latched
  assign fifo_pop = (state_reg == ST_DATA) && rd_reg && hit_fifo;
  assign stat_read = (state_reg == ST_DATA) && rd_reg && hit_stat;

  ech_irq_fifo u_irq_fifo (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .push_i(chan_irq_i),
    .push_data_i(chan_irq_id_i),
    .pop_i(fifo_pop),
    .pop_data_o(fifo_head),
    .empty_o(fifo_empty),
    .full_o(fifo_full),
    .count_o(fifo_count)
  );

  // ------------------------------------------------------------------
  // Read words of the local registers
  // ------------------------------------------------------------------
  reg [`ECH_DATA_W-1:0] fifo_word;
  reg [`ECH_DATA_W-1:0] stat_word;

  always @* begin
    fifo_word = {`ECH_DATA_W{1'b0}};
    fifo_word[`ECH_CHAN_W-1:0] = fifo_head;
    // Valid flag tells software when the FIFO has run dry
    fifo_word[`ECH_FIFO_VALID_BIT] = !fifo_empty;
    stat_word = {`ECH_DATA_W{1'b0}};
    stat_word[`ECH_FIFO_CNT_W-1:0] = fifo_count;
    stat_word[`ECH_STAT_OVF_BIT] = ovf_reg;
  end

  // ------------------------------------------------------------------
  // Read data selection
  // ------------------------------------------------------------------
  reg [`ECH_DATA_W-1:0] rdata_next;

  always @* begin
    rdata_next = core_rdata_i;
    if (hit_ctrl) begin
      rdata_next = ctrl_reg;
    end else if (hit_fifo) begin
      rdata_next = fifo_word;
    end else if (hit_stat) begin
      rdata_next = stat_word;
    end
  end

  // ------------------------------------------------------------------
  // Start-up and access sequencer
  // ------------------------------------------------------------------
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= ST_INIT;
      init_cnt_reg <= {`ECH_INIT_CNT_W{1'b0}};
      init_done_reg <= 1'b0;
      addr_reg <= {`ECH_ADDR_W{1'b0}};
      wdata_reg <= {`ECH_DATA_W{1'b0}};
      rd_reg <= 1'b0;
      ctrl_reg <= `ECH_MAIN_CTRL_RST;
      dout_reg <= {`ECH_DATA_W{1'b0}};
      dout_oe_reg <= 1'b0;
      ack_oe_reg <= 1'b0;
      core_wr_reg <= 1'b0;
      core_rd_reg <= 1'b0;
    end else begin
      core_wr_reg <= 1'b0;
      core_rd_reg <= 1'b0;
      case (state_reg)
        ST_INIT: begin
          // The main control default reloads here as well, and no access is taken meanwhile
          ctrl_reg <= `ECH_MAIN_CTRL_RST;
          init_cnt_reg <= init_cnt_reg + 1'b1;
          if (init_cnt_reg == `ECH_INIT_CYCLES - 1'b1) begin
            init_done_reg <= 1'b1;
            state_reg <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          // Strobes with chip select high never leave this state
          if (sel_s) begin
            addr_reg <= addr_s;
            wdata_reg <= data_s;
            rd_reg <= rd_s;
            state_reg <= ST_REQ;
          end
        end
        ST_REQ: begin
          if (!rd_reg && hit_ctrl) begin
            ctrl_reg <= wdata_reg;
          end
          // Writes to the FIFO and status addresses have no effect
          if (!hit_local) begin
            core_wr_reg <= !rd_reg;
            core_rd_reg <= rd_reg;
          end
          state_reg <= ST_DATA;
        end
        ST_DATA: begin
          // Byte and acknowledge leave together, so ack never beats the data
          if (rd_reg) begin
            dout_reg <= rdata_next;
            dout_oe_reg <= 1'b1;
          end
          ack_oe_reg <= 1'b1;
          state_reg <= ST_ACK;
        end
        ST_ACK: begin
          // Held until the host lets go of the strobe or the select
          if (!sel_s) begin
            ack_oe_reg <= 1'b0;
            dout_oe_reg <= 1'b0;
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Overflow flag, set wins over the clear by a status read
  // ------------------------------------------------------------------
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ovf_reg <= 1'b0;
    end else if (chan_irq_i && fifo_full) begin
      // Push is lost even when a pop frees a slot in the same cycle
      ovf_reg <= 1'b1;
    end else if (stat_read) begin
      ovf_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Interrupt request output
  // ------------------------------------------------------------------
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      irq_oe_reg <= 1'b0;
    end else begin
      // Low while any entry waits, released once the FIFO is drained
      irq_oe_reg <= !fifo_empty;
    end
  end

  // ------------------------------------------------------------------
  // PCM output drive enable
  // ------------------------------------------------------------------
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pcm_en_reg <= 1'b0;
    end else begin
      // Pin and control bit both high or the PCM outputs float
      pcm_en_reg <= ode_s && ctrl_reg[`ECH_CTRL_ODE_BIT];
    end
  end

  assign host_data_bus_o = dout_reg;
  assign host_data_bus_oe_o = dout_oe_reg;
  assign transfer_ack_n_o = 1'b0;
  assign transfer_ack_n_oe_o = ack_oe_reg;
  assign irq_n_o = 1'b0;
  assign irq_n_oe_o = irq_oe_reg;
  assign pcm_drive_en_o = pcm_en_reg;
  assign core_wr_o = core_wr_reg;
  assign core_rd_o = core_rd_reg;
  assign core_addr_o = addr_reg;
  assign core_wdata_o = wdata_reg;
  assign main_ctrl_o = ctrl_reg;
  assign init_done_o = init_done_reg;

endmodule

// ### verif/ech_host_port_props.sv
// Pin-level checker for the echo canceller host port.
// Assumes the host holds address and direction until acknowledge ends.
`timescale 1ns/1ps
`include "ech_consts.vh"

module ech_host_port_chk (
  input wire clk_sys_i, // Clock
  input wire rst_i, // Reset
  input wire cs_n_i, // Select
  input wire data_strobe_n_i, // Strobe
  input wire rd_wr_n_i, // Direction
  input wire [`ECH_ADDR_W-1:0] host_addr_bus_i, // Address
  input wire host_data_bus_oe_o, // Data driven
  input wire transfer_ack_n_oe_o, // Ack pulled
  input wire irq_n_oe_o, // Irq pulled
  input wire output_drive_enable_i, // Drive pin
  input wire pcm_drive_en_o, // PCM enable
  input wire chan_irq_i, // Channel irq
  input wire core_wr_o, // Core write
  input wire core_rd_o, // Core read
  input wire [`ECH_DATA_W-1:0] main_ctrl_o, // Control
  input wire init_done_o // Started
);
  // ----
  // Properties
  // ----
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  sequence s_sel; init_done_o && !cs_n_i && !data_strobe_n_i; endsequence
  sequence s_idle; cs_n_i || data_strobe_n_i; endsequence
  sequence s_start; init_done_o && $fell(cs_n_i || data_strobe_n_i); endsequence
  // Two sync stages sit between the pins and the sequencer
  property p_ack_cause;
    $rose(transfer_ack_n_oe_o) |-> !$past(cs_n_i, 3) && !$past(data_strobe_n_i, 3);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without select");
  property p_ack_end; s_idle [*4] |-> !transfer_ack_n_oe_o; endproperty
  a_ack_end: assert property (p_ack_end) else $error("ack held after release");
  property p_ack_prompt; s_start ##1 s_sel [*4] |=> transfer_ack_n_oe_o; endproperty
  a_ack_prompt: assert property (p_ack_prompt) else $error("ack missing");
  property p_dir; $rose(transfer_ack_n_oe_o) |-> host_data_bus_oe_o == rd_wr_n_i; endproperty
  a_dir: assert property (p_dir) else $error("data direction wrong");
  property p_oe_read; host_data_bus_oe_o |-> transfer_ack_n_oe_o && rd_wr_n_i; endproperty
  a_oe_read: assert property (p_oe_read) else $error("data driven outside read");
  property p_no_cs;
    cs_n_i [*6] |-> !transfer_ack_n_oe_o && !core_wr_o && !core_rd_o;
  endproperty
  a_no_cs: assert property (p_no_cs) else $error("access without select");
  property p_pcm_on;
    pcm_drive_en_o |-> $past(output_drive_enable_i, 3) && $past(main_ctrl_o[6]);
  endproperty
  a_pcm_on: assert property (p_pcm_on) else $error("pcm enabled wrongly");
  property p_pcm_off; !output_drive_enable_i [*4] |-> !pcm_drive_en_o; endproperty
  a_pcm_off: assert property (p_pcm_off) else $error("pcm not floated");
  property p_irq_raise; chan_irq_i |-> ##[1:2] irq_n_oe_o; endproperty
  a_irq_raise: assert property (p_irq_raise) else $error("irq not raised");
  property p_irq_drop;
    $fell(irq_n_oe_o) |-> host_addr_bus_i == `ECH_ADDR_IRQ_FIFO && rd_wr_n_i;
  endproperty
  a_irq_drop: assert property (p_irq_drop) else $error("irq dropped early");
  property p_init;
    $fell(rst_i) |-> (!transfer_ack_n_oe_o && main_ctrl_o == `ECH_MAIN_CTRL_RST) [*8];
  endproperty
  a_init: assert property (p_init) else $error("start-up state wrong");
endmodule

bind ech_host_port ech_host_port_chk chk_u (.clk_sys_i, .rst_i, .cs_n_i, .data_strobe_n_i,
  .rd_wr_n_i, .host_addr_bus_i, .host_data_bus_oe_o, .transfer_ack_n_oe_o, .irq_n_oe_o,
  .output_drive_enable_i, .pcm_drive_en_o, .chan_irq_i, .core_wr_o, .core_rd_o,
  .main_ctrl_o, .init_done_o);

// ### verif/ech_host_model.sv
// Behavioural host processor driving register cycles on the port.
// Assumes the bench resolves the data and acknowledge wires.
`timescale 1ns/1ps
`include "ech_consts.vh"

module ech_host_model (
  input wire clk_sys_i, // Clock
  input wire ack_n_i, // Resolved acknowledge
  input wire [`ECH_DATA_W-1:0] bus_i, // Resolved data
  output reg cs_n_o, // Chip select
  output reg data_strobe_n_o, // Strobe
  output reg rd_wr_n_o, // Direction
  output reg [`ECH_ADDR_W-1:0] addr_o, // Address
  output reg [`ECH_DATA_W-1:0] data_o // Data, inverted when released
);
  initial begin
    {cs_n_o, data_strobe_n_o, rd_wr_n_o} = 3'h7;
    addr_o = 11'h000;
    data_o = 8'h00;
  end
  // Released bus shows the inverse so a stale value never passes
  task automatic access(input logic rd, input logic [10:0] a, input logic [7:0] wd,
      output logic [7:0] rdata, output logic ok);
    int n;
    ok = 0;
    rdata = 8'h00;
    @(posedge clk_sys_i) #1;
    rd_wr_n_o = rd;
    addr_o = a;
    data_o = rd ? ~data_o : wd;
    {cs_n_o, data_strobe_n_o} = 2'h0;
    // Answer is taken at the edge that samples it, release comes after
    for (n = 0; n < 20 && !ok; n++) begin
      @(posedge clk_sys_i);
      if (ack_n_i === 1'b0) begin
        ok = 1;
        rdata = bus_i;
      end
    end
    #1;
    {cs_n_o, data_strobe_n_o} = 2'h3;
    data_o = ~data_o;
    for (n = 0; n < 8 && ack_n_i !== 1'b1; n++) @(posedge clk_sys_i) #1;
    repeat (2) @(posedge clk_sys_i) #1;
  endtask
  task automatic poke(input logic cs, input logic ds);
    @(posedge clk_sys_i) #1;
    {cs_n_o, data_strobe_n_o, rd_wr_n_o} = {cs, ds, 1'b0};
    addr_o = `ECH_ADDR_MAIN_CTRL;
    data_o = 8'hff;
    repeat (12) @(posedge clk_sys_i) #1;
    {cs_n_o, data_strobe_n_o} = 2'h3;
    data_o = 8'h00;
    repeat (3) @(posedge clk_sys_i) #1;
  endtask
endmodule

// ### verif/tb.sv
// Self-checking bench for the echo canceller host port.
// Assumes open-drain wires are pulled up and the core answers combinationally.
`timescale 1ns/1ps
`include "ech_consts.vh"

module tb;
  reg clk_sys_i, rst_i, output_drive_enable, chan_irq;
  reg [4:0] chan_id;
  wire cs_n, ds_n, rw, bus_oe, ack_o, ack_oe, irq_o, irq_oe, pcm, core_wr, core_rd, done;
  wire [10:0] addr, core_addr;
  wire [7:0] host_d, bus_o, core_wd, ctrl;
  wire [7:0] bus_w = bus_oe ? bus_o : host_d;
  wire ack_w = ack_oe ? ack_o : 1'b1;
  wire irq_w = irq_oe ? irq_o : 1'b1;
  wire [7:0] core_rd_data = core_addr[7:0] ^ 8'h5a;
  logic [7:0] wr_seen = 8'h00, rd_seen = 8'h00, last_wd, rd, w0;
  logic [10:0] last_wa;
  logic ok;
  int bad_count = 0, n_compared = 0;

  ech_host_port dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .cs_n_i(cs_n),
    .data_strobe_n_i(ds_n), .rd_wr_n_i(rw), .host_addr_bus_i(addr), .host_data_bus_i(bus_w),
    .host_data_bus_o(bus_o), .host_data_bus_oe_o(bus_oe), .transfer_ack_n_o(ack_o),
    .transfer_ack_n_oe_o(ack_oe), .irq_n_o(irq_o), .irq_n_oe_o(irq_oe),
    .output_drive_enable_i(output_drive_enable), .pcm_drive_en_o(pcm), .chan_irq_i(chan_irq),
    .chan_irq_id_i(chan_id), .core_wr_o(core_wr), .core_rd_o(core_rd),
    .core_addr_o(core_addr), .core_wdata_o(core_wd), .core_rdata_i(core_rd_data),
    .main_ctrl_o(ctrl), .init_done_o(done));
  ech_host_model host_u (.clk_sys_i(clk_sys_i), .ack_n_i(ack_w), .bus_i(bus_w),
    .cs_n_o(cs_n), .data_strobe_n_o(ds_n), .rd_wr_n_o(rw), .addr_o(addr), .data_o(host_d));

  // ----
  // Helpers
  // ----
  initial begin
    clk_sys_i = 0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    if (core_wr === 1'b1) begin
      wr_seen <= wr_seen + 8'h01;
      last_wa <= core_addr;
      last_wd <= core_wd;
    end
    if (core_rd === 1'b1) begin
      rd_seen <= rd_seen + 8'h01;
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic end_sim;
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // ----
  // Scenarios
  // ----
  task automatic t_reset;
    chk({7'h0, done}, 8'h00);
    chk(ctrl, 8'h00);
    chk({7'h0, pcm}, 8'h00);
    for (int n = 0; n < 40 && done !== 1'b1; n++) cyc(1);
    chk({7'h0, done}, 8'h01);
    cyc(3);
  endtask
  task automatic t_ctrl;
    host_u.access(1'b0, `ECH_ADDR_MAIN_CTRL, 8'h40, rd, ok);
    chk({7'h0, ok}, 8'h01);
    chk(ctrl, 8'h40);
    host_u.access(1'b1, `ECH_ADDR_MAIN_CTRL, 8'h00, rd, ok);
    chk(rd, 8'h40);
    output_drive_enable = 1;
    cyc(5);
    chk({7'h0, pcm}, 8'h01);
    output_drive_enable = 0;
    cyc(5);
    chk({7'h0, pcm}, 8'h00);
    output_drive_enable = 1;
    host_u.access(1'b0, `ECH_ADDR_MAIN_CTRL, 8'hbf, rd, ok);
    cyc(5);
    chk({7'h0, pcm}, 8'h00);
    host_u.access(1'b1, `ECH_ADDR_MAIN_CTRL, 8'h00, rd, ok);
    chk(rd, 8'hbf);
  endtask
  task automatic t_core;
    logic [7:0] r0;
    w0 = wr_seen;
    r0 = rd_seen;
    host_u.access(1'b0, 11'h400, 8'hc3, rd, ok);
    chk(wr_seen - w0, 8'h01);
    chk({5'h0, last_wa[10:8]}, 8'h04);
    chk(last_wa[7:0], 8'h00);
    chk(last_wd, 8'hc3);
    chk(ctrl, 8'hbf);
    host_u.access(1'b1, 11'h7ff, 8'h00, rd, ok);
    chk(rd, 8'ha5);
    host_u.access(1'b1, 11'h201, 8'h00, rd, ok);
    chk(rd, 8'h5b);
    chk(rd_seen - r0, 8'h02);
  endtask
  task automatic t_nocs;
    w0 = wr_seen;
    host_u.poke(1'b1, 1'b0);
    host_u.poke(1'b0, 1'b1);
    chk(wr_seen, w0);
    chk(ctrl, 8'hbf);
  endtask
  task automatic t_irq;
    chan_irq = 1;
    chan_id = 5'h03;
    cyc(1);
    chan_id = 5'h09;
    cyc(1);
    chan_irq = 0;
    cyc(3);
    chk({7'h0, irq_w}, 8'h00);
    host_u.access(1'b1, `ECH_ADDR_IRQ_STAT, 8'h00, rd, ok);
    chk(rd, 8'h02);
    host_u.access(1'b1, `ECH_ADDR_IRQ_FIFO, 8'h00, rd, ok);
    chk(rd, 8'h83);
    chk({7'h0, irq_w}, 8'h00);
    host_u.access(1'b1, `ECH_ADDR_IRQ_FIFO, 8'h00, rd, ok);
    chk(rd, 8'h89);
    chk({7'h0, irq_w}, 8'h01);
    host_u.access(1'b1, `ECH_ADDR_IRQ_FIFO, 8'h00, rd, ok);
    chk(rd, 8'h00);
    chk({7'h0, ok}, 8'h01);
    chan_irq = 1;
    for (int n = 0; n < 33; n++) begin
      chan_id = n[4:0];
      cyc(1);
    end
    chan_irq = 0;
    cyc(3);
    host_u.access(1'b1, `ECH_ADDR_IRQ_STAT, 8'h00, rd, ok);
    chk(rd, 8'ha0);
    host_u.access(1'b1, `ECH_ADDR_IRQ_STAT, 8'h00, rd, ok);
    chk(rd, 8'h20);
    host_u.access(1'b1, `ECH_ADDR_IRQ_FIFO, 8'h00, rd, ok);
    chk(rd, 8'h80);
    chk({7'h0, irq_w}, 8'h00);
  endtask
  task automatic t_rerun;
    rst_i = 1;
    cyc(2);
    chk({7'h0, irq_w}, 8'h01);
    chk({7'h0, ack_w}, 8'h01);
    rst_i = 0;
    t_reset;
    host_u.access(1'b1, `ECH_ADDR_IRQ_STAT, 8'h00, rd, ok);
    chk(rd, 8'h00);
  endtask

  initial begin
    rst_i = 1;
    output_drive_enable = 0;
    chan_irq = 0;
    chan_id = 5'h00;
    repeat (4) @(posedge clk_sys_i);
    #1 rst_i = 0;
    t_reset;
    t_ctrl;
    t_core;
    t_nocs;
    t_irq;
    t_rerun;
    end_sim;
  end
  initial begin
    #400000;
    bad_count++;
    end_sim;
  end
endmodule
